// file: relay_bank_cfg.svh
// Register offsets, field positions and constant values for the relay bank.
`ifndef RELAY_BANK_CFG_SVH
`define RELAY_BANK_CFG_SVH
`define REG_IDENTITY 2'h0
`define REG_FIXED 2'h1
`define REG_UNUSED 2'h2
`define REG_CHANNEL 2'h3
`define ID_TERM_LSB 0
`define ID_TERM_W 3
`define ID_MOD_LSB 3
`define ID_MOD_W 5
`define ID_NO_TERM 3'h7
`define CHANNEL_RESET 8'h00
`endif

// file: relay_bank_pkg.sv
// Types shared by the relay bank register interface.
package relay_bank_pkg;
	// Kind of backplane access seen in one cycle.
	typedef enum logic [1:0] {
		ACC_NONE = 2'h0,
		ACC_READ = 2'h1,
		ACC_WRITE = 2'h2
	} access_type;
endpackage

// file: relay_bank.sv
// Backplane register interface of the eight-channel relay actuator card.
//
// What this block and the host must do
// R1 - Relays de-energize on reset or open command
// R2 - Register 0 read returns identity byte
// R3 - Identity: upper five module, lower three terminal
// R4 - No terminal module forces terminal bits ones
// R5 - Register 1 read returns fixed constant
// R6 - Register 3 read returns channel states
// R7 - Host treats read values as signed
// R8 - Any register 0 write opens all channels
// R9 - Backplane reset equals register 0 write
// R10 - Register 3 write loads channel control word
// R11 - Host uses primitive read/write for service
// R12 - Unused accesses leave control word; read zero
// R13 - Control word in flip-flops, reset clears
`include "relay_bank_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module relay_bank
	import relay_bank_pkg::*;
#(
	// Component module code; value is arbitrary.
	parameter logic [4:0] MODULE_CODE = 5'h15,
	// Hardwired constant, all sixteen bits; value is arbitrary.
	parameter logic [15:0] FIXED_VALUE = 16'h00a5
) (
	input wire logic clk_i, // System clock, 10 MHz.
	input wire logic nrst_i, // Synchronous active-low system reset.
	input wire logic acc_reset_i, // Backplane accessory reset, active high.
	input wire logic [1:0] reg_addr_i, // Register number.
	input wire logic rd_i, // Read strobe, one cycle.
	input wire logic wr_i, // Write strobe, one cycle.
	input wire logic [7:0] wr_data_i, // Write data.
	input wire logic [2:0] term_id_i, // Terminal module identity lines.
	input wire logic term_present_i, // High when a terminal module is fitted.
	output logic [15:0] rd_data_o, // Read data, valid one cycle after rd_i.
	output logic rd_valid_o, // Read data qualifier, one-cycle pulse.
	output logic [7:0] relay_o // Relay drivers, one means energized.
);
	// Registered state and next values.
	logic [7:0] channel_r, channel_nxt;
	logic [15:0] rd_data_r, rd_data_nxt;
	logic rd_valid_r, rd_valid_nxt;
	logic [2:0] rst_sync_r; // Accessory reset synchronizer.
	logic [2:0] term_sync_r; // Presence synchronizer.
	logic [2:0] tid_a_r, tid_b_r, tid_c_r; // Terminal identity synchronizer.
	logic [2:0] tid_r, tid_nxt; // Accepted terminal identity.
	logic present_r, present_nxt; // Accepted presence.
	logic acc_rst_r, acc_rst_nxt; // Accepted accessory reset level.
	access_type acc;

	// Classify the current access; a write takes priority over a read.
	always_comb begin
		if (wr_i) begin
			acc = ACC_WRITE;
		end else if (rd_i) begin
			acc = ACC_READ;
		end else begin
			acc = ACC_NONE;
		end
	end

	// Pin inputs count as changed once the second and third stages agree.
	always_comb begin
		acc_rst_nxt = acc_rst_r;
		present_nxt = present_r;
		tid_nxt = tid_r;
		if (rst_sync_r[1] == rst_sync_r[2]) begin
			acc_rst_nxt = rst_sync_r[2];
		end
		if (term_sync_r[1] == term_sync_r[2]) begin
			present_nxt = term_sync_r[2];
		end
		if (tid_b_r == tid_c_r) begin
			tid_nxt = tid_c_r;
		end
	end

	// Channel word: resets and register 0 writes open every relay.
	always_comb begin
		channel_nxt = channel_r;
		if (acc_rst_r) begin
			channel_nxt = `CHANNEL_RESET; // R9 R1
		end else if (acc == ACC_WRITE) begin
			if (reg_addr_i == `REG_IDENTITY) begin
				channel_nxt = `CHANNEL_RESET; // R8 R1
			end else if (reg_addr_i == `REG_CHANNEL) begin
				channel_nxt = wr_data_i; // R10
			end else begin
				// Registers 1 and 2 take no data.
				channel_nxt = channel_r; // R12
			end
		end
	end

	// Read mux.
	always_comb begin
		rd_data_nxt = 16'h0000;
		rd_valid_nxt = 1'b0;
		if (acc == ACC_READ) begin
			rd_valid_nxt = 1'b1;
			unique case (reg_addr_i)
				`REG_IDENTITY: begin
					rd_data_nxt[`ID_MOD_LSB +: `ID_MOD_W] = MODULE_CODE; // R2 R3
					rd_data_nxt[`ID_TERM_LSB +: `ID_TERM_W] =
						present_r ? tid_r : `ID_NO_TERM; // R4
				end
				`REG_FIXED: begin
					rd_data_nxt = FIXED_VALUE; // R5
				end
				`REG_CHANNEL: begin
					rd_data_nxt[7:0] = channel_r; // R6
				end
				`REG_UNUSED: begin
					rd_data_nxt = 16'h0000; // R12
				end
			endcase
		end
	end

	// Register everything; system reset clears the control word.
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			channel_r <= `CHANNEL_RESET; // R13 R1
			rd_data_r <= 16'h0000;
			rd_valid_r <= 1'b0;
			rst_sync_r <= 3'h0;
			term_sync_r <= 3'h0;
			tid_a_r <= 3'h0;
			tid_b_r <= 3'h0;
			tid_c_r <= 3'h0;
			tid_r <= `ID_NO_TERM;
			present_r <= 1'b0;
			acc_rst_r <= 1'b0;
		end else begin
			channel_r <= channel_nxt; // R13
			rd_data_r <= rd_data_nxt;
			rd_valid_r <= rd_valid_nxt;
			rst_sync_r <= {rst_sync_r[1:0], acc_reset_i};
			term_sync_r <= {term_sync_r[1:0], term_present_i};
			tid_a_r <= term_id_i;
			tid_b_r <= tid_a_r;
			tid_c_r <= tid_b_r;
			tid_r <= tid_nxt;
			present_r <= present_nxt;
			acc_rst_r <= acc_rst_nxt;
		end
	end

	assign rd_data_o = rd_data_r;
	assign rd_valid_o = rd_valid_r;
	assign relay_o = channel_r;

	// Assertions.
	// Any register 0 write opens every relay on the next edge.
	AST_WR0_OPENS: assert property (@(posedge clk_i) // R8
		disable iff (!nrst_i)
		wr_i && reg_addr_i == `REG_IDENTITY |=> relay_o == 8'h00)
		else $error("Register 0 write did not open relays.");
	// A register 3 write lands unless the accessory reset is holding.
	AST_WR3_LOADS: assert property (@(posedge clk_i) // R10
		disable iff (!nrst_i)
		wr_i && reg_addr_i == `REG_CHANNEL && !acc_rst_r
		|=> relay_o == $past(wr_data_i))
		else $error("Register 3 write did not load channels.");
	// The hardwired register answers with the same value every time.
	AST_RD_FIXED: assert property (@(posedge clk_i) // R5
		disable iff (!nrst_i)
		rd_i && !wr_i && reg_addr_i == `REG_FIXED
		|=> rd_valid_o && rd_data_o == FIXED_VALUE)
		else $error("Fixed register read wrong.");
	// The status read shows the channel word as it stood at the request.
	AST_RD_STATUS: assert property (@(posedge clk_i) // R6
		disable iff (!nrst_i)
		rd_i && !wr_i && reg_addr_i == `REG_CHANNEL
		|=> rd_data_o == {8'h00, $past(relay_o)})
		else $error("Status read does not match channels.");
	// The identity byte carries the module code in its upper five bits.
	AST_RD_ID_MOD: assert property (@(posedge clk_i) // R2 R3
		disable iff (!nrst_i)
		rd_i && !wr_i && reg_addr_i == `REG_IDENTITY
		|=> rd_data_o[7:3] == MODULE_CODE && rd_data_o[15:8] == 8'h00)
		else $error("Identity module field wrong.");
	// A fitted terminal module reports its own type in the low bits.
	AST_RD_ID_TERM: assert property (@(posedge clk_i) // R3
		disable iff (!nrst_i)
		rd_i && !wr_i && reg_addr_i == `REG_IDENTITY && present_r
		|=> rd_data_o[2:0] == $past(tid_r))
		else $error("Identity terminal field wrong.");
	// Without a terminal module the low three bits read as ones.
	AST_NO_TERM: assert property (@(posedge clk_i) // R4
		disable iff (!nrst_i)
		rd_i && !wr_i && reg_addr_i == `REG_IDENTITY && !present_r
		|=> rd_data_o[2:0] == 3'h7)
		else $error("Missing terminal not flagged.");
	// The accepted accessory reset level opens every relay.
	AST_ACC_RESET: assert property (@(posedge clk_i) // R9 R1
		disable iff (!nrst_i)
		acc_rst_r |=> relay_o == 8'h00)
		else $error("Accessory reset did not open relays.");
	// The settled reset pin reaches the relays two edges later.
	sequence acc_pin_settled_seq;
		rst_sync_r[1] && rst_sync_r[2];
	endsequence
	AST_PIN_RESET: assert property (@(posedge clk_i) // R9 R1
		disable iff (!nrst_i)
		acc_pin_settled_seq |-> ##2 relay_o == 8'h00)
		else $error("Accessory reset pin did not open relays.");
	// Writes to registers 1 and 2 leave the channel word alone.
	AST_UNUSED: assert property (@(posedge clk_i) // R12
		disable iff (!nrst_i)
		wr_i && (reg_addr_i == `REG_FIXED || reg_addr_i == `REG_UNUSED)
		&& !acc_rst_r |=> $stable(relay_o))
		else $error("Unused write changed channels.");
	// Register 2 has no contents and reads as zero.
	AST_RD_UNUSED: assert property (@(posedge clk_i) // R12
		disable iff (!nrst_i)
		rd_i && !wr_i && reg_addr_i == `REG_UNUSED
		|=> rd_valid_o && rd_data_o == 16'h0000)
		else $error("Unused register read not zero.");
	// With no write and no reset the relays hold their last command.
	AST_HOLD: assert property (@(posedge clk_i) // R13
		disable iff (!nrst_i)
		!wr_i && !acc_rst_r |=> $stable(relay_o))
		else $error("Relays changed without a command.");
	// System reset clears the channel word; this one is never disabled.
	AST_RST_CLEAR: assert property (@(posedge clk_i) // R13
		!nrst_i |=> relay_o == 8'h00)
		else $error("System reset did not clear channels.");
endmodule
`default_nettype wire

// file: host_model.sv
// Host model that drives the relay bank register strobes.
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic clk_i,
	input wire logic [15:0] rd_data_i,
	input wire logic rd_valid_i,
	output logic [1:0] addr_o,
	output logic rd_o,
	output logic wr_o,
	output logic [7:0] data_o
);
	initial begin
		addr_o = 2'h0;
		rd_o = 1'b0;
		wr_o = 1'b0;
		data_o = 8'h00;
	end
	// One write strobe; released lines show the inverse value.
	task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_o <= a;
		data_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		data_o <= ~d;
	endtask
	// One read strobe; data stays unknown if no answer comes.
	task automatic rd_reg(input logic [1:0] a, output logic [15:0] q);
		q = 'x;
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		repeat (3) begin
			#1;
			if (rd_valid_i === 1'b1) q = rd_data_i;
			@(posedge clk_i);
		end
	endtask
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the relay bank register interface.
`include "relay_bank_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic acc_reset_i = 1'b0;
	logic [2:0] term_id_i = 3'h2;
	logic term_present_i = 1'b1;
	logic [1:0] addr;
	logic rd;
	logic wr;
	logic [7:0] wdat;
	logic [7:0] relay;
	logic [15:0] rdat;
	logic [15:0] q;
	logic rvld;
	int miscompares = 0;
	int cmp_count = 0;
	always #50 clk_i = ~clk_i;
	// Module code and constant values are arbitrary.
	relay_bank #(.MODULE_CODE(5'h0b), .FIXED_VALUE(16'h5a3c)) dut_u (
		.clk_i(clk_i), .nrst_i(nrst_i), .acc_reset_i(acc_reset_i),
		.reg_addr_i(addr), .rd_i(rd), .wr_i(wr), .wr_data_i(wdat),
		.term_id_i(term_id_i), .term_present_i(term_present_i),
		.rd_data_o(rdat), .rd_valid_o(rvld), .relay_o(relay));
	host_model host_u (.clk_i(clk_i), .rd_data_i(rdat), .rd_valid_i(rvld),
		.addr_o(addr), .rd_o(rd), .wr_o(wr), .data_o(wdat));
	task automatic report_and_stop;
		$display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
		if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	// A missing read answer is counted and ends the run.
	task automatic rchk(input logic [1:0] a, input logic [15:0] e);
		host_u.rd_reg(a, q);
		chk("rd_data_o", e, q);
		chk("rd_valid_o", 16'h0000, {15'h0000, rvld});
		if ($isunknown(q)) report_and_stop();
	endtask
	task automatic lchk(input logic [7:0] e);
		repeat (2) @(posedge clk_i);
		#1;
		chk("relay_o", {8'h00, e}, {8'h00, relay});
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		lchk(8'h00);
		rchk(`REG_CHANNEL, 16'h0000);
		rchk(`REG_IDENTITY, {8'h00, 5'h0b, 3'h2});
		term_present_i <= 1'b0;
		repeat (5) @(posedge clk_i);
		rchk(`REG_IDENTITY, {8'h00, 5'h0b, `ID_NO_TERM});
		rchk(`REG_FIXED, 16'h5a3c);
		for (int i = 0; i < 8; i++) begin
			host_u.wr_reg(`REG_CHANNEL, 8'h01 << i);
			lchk(8'h01 << i);
			rchk(`REG_CHANNEL, 16'h0001 << i);
		end
		chk("status_signed", 16'hff80, {{8{q[7]}}, q[7:0]});
		host_u.wr_reg(`REG_FIXED, 8'hff);
		host_u.wr_reg(`REG_UNUSED, 8'hff);
		lchk(8'h80);
		rchk(`REG_UNUSED, 16'h0000);
		host_u.wr_reg(`REG_IDENTITY, 8'h3c);
		lchk(8'h00);
		host_u.wr_reg(`REG_CHANNEL, 8'h5a);
		lchk(8'h5a);
		acc_reset_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		lchk(8'h00);
		host_u.wr_reg(`REG_CHANNEL, 8'hff);
		lchk(8'h00);
		@(posedge clk_i);
		acc_reset_i <= 1'b0;
		repeat (5) @(posedge clk_i);
		host_u.wr_reg(`REG_CHANNEL, 8'ha5);
		lchk(8'ha5);
		@(posedge clk_i);
		nrst_i <= 1'b0;
		lchk(8'h00);
		report_and_stop();
	end
endmodule
`default_nettype wire
